/* File: hw/homing_pkg.sv */
// Constants, state type and method codes for the homing sequencer (methods 6 to 11)
// Operation
// - Method 6, switch low at start: slow reverse, stop on index after rising edge.
// - Method 6, switch high: fast forward, falling edge, slow reverse, index after rise.
// - Method 7, switch low: fast forward, rise, slow reverse, index after fall.
// - Method 7, forward limit: fast reverse, rise, slow reverse, index after fall.
// - Method 7, switch high: slow reverse, stop on index after falling edge.
// - Method 8, switch low: fast forward, rise slow reverse, fall slow forward, index.
// - Method 8, forward limit: fast reverse, rise slow reverse, fall slow forward.
// - Method 8, switch high: slow reverse, fall slow forward, index after rise.
// - Method 9, switch low: fast forward, rise slow forward, fall slow reverse.
// - Method 9, forward limit: fast reverse, rise slow forward, fall slow reverse.
// - Method 9, switch high: slow forward, fall slow reverse, index after rise.
// - Method 10, switch low: fast forward, rise slow forward, past fall to index.
// - Method 10, forward limit: fast reverse, rise slow forward, index after fall.
// - Method 10, switch high: slow forward, stop on index after falling edge.
// - Method 11, switch low: fast reverse, rise slow forward, index after fall.
// - Method 11, reverse limit: fast forward, rise slow forward, index after fall.
// - Method 11, switch high: slow forward, stop on index after falling edge.
// - Fast and slow speeds come from two separately configurable settings.
package homing_pkg;

  localparam int SPEED_W  = 16;
  localparam int METHOD_W = 8;
  localparam int PIN_N    = 4;

  localparam int PIN_HOME = 0;
  localparam int PIN_FLIM = 1;
  localparam int PIN_RLIM = 2;
  localparam int PIN_IDX  = 3;

  localparam logic [METHOD_W-1:0] MTH_06 = 8'h06;
  localparam logic [METHOD_W-1:0] MTH_07 = 8'h07;
  localparam logic [METHOD_W-1:0] MTH_08 = 8'h08;
  localparam logic [METHOD_W-1:0] MTH_09 = 8'h09;
  localparam logic [METHOD_W-1:0] MTH_10 = 8'h0A;
  localparam logic [METHOD_W-1:0] MTH_11 = 8'h0B;

  localparam logic DIR_FWD = 1'b1;
  localparam logic DIR_REV = 1'b0;

  localparam logic [SPEED_W-1:0]  SPEED_ZERO  = 16'h0000;
  localparam logic [METHOD_W-1:0] METHOD_RST  = 8'h00;
  localparam logic [PIN_N-1:0]    PINS_RST    = 4'h0;

  typedef enum logic [2:0] {
    S_IDLE,
    S_FAST,
    S_BACK,
    S_SLOW1,
    S_SLOW2,
    S_ARM,
    S_DONE
  } home_state_e;

endpackage : homing_pkg

/* File: hw/homing_seq.sv */
// Homing sequencer: index pulse origin, home switch deceleration point, methods 6 to 11
`timescale 1ns/1ps
module homing_seq
  import homing_pkg::*;
(
  input  wire logic                clock_i,       // 100 MHz clock
  input  wire logic                rstn_i,        // Async reset, active low
  input  wire logic                start_i,       // Homing start pulse
  input  wire logic                stop_i,        // Abort pulse, back to idle
  input  wire logic [METHOD_W-1:0] method_i,      // Method code, read at start
  input  wire logic [SPEED_W-1:0]  fast_speed_i,  // Deceleration point search speed
  input  wire logic [SPEED_W-1:0]  slow_speed_i,  // Origin search speed
  input  wire logic                home_switch_i, // Home switch pin
  input  wire logic                fwd_limit_i,   // Forward limit pin
  input  wire logic                rev_limit_i,   // Reverse limit pin
  input  wire logic                index_i,       // Encoder index pin
  output logic                     dir_fwd_o,     // 1 forward, 0 reverse
  output logic                     fast_o,        // Fast speed selected
  output logic                     moving_o,      // Motion commanded
  output logic [SPEED_W-1:0]       speed_o,       // Commanded speed
  output logic                     done_o,        // Homing complete
  output logic                     error_o        // Last start had a bad method
);

  // Synchroniser and edge detection
  logic [PIN_N-1:0] pin_meta_q;
  logic [PIN_N-1:0] pin_sync_q;
  logic             hs_prev_q;
  logic             idx_prev_q;
  wire  [PIN_N-1:0] pins_w = {index_i, rev_limit_i, fwd_limit_i, home_switch_i};

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_q <= PINS_RST;
      pin_sync_q <= PINS_RST;
      hs_prev_q  <= 1'b0;
      idx_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= pins_w;
      pin_sync_q <= pin_meta_q;
      hs_prev_q  <= pin_sync_q[PIN_HOME];
      idx_prev_q <= pin_sync_q[PIN_IDX];
    end
  end

  wire hs_w       = pin_sync_q[PIN_HOME];
  wire flim_w     = pin_sync_q[PIN_FLIM];
  wire rlim_w     = pin_sync_q[PIN_RLIM];
  wire hs_rise_w  = hs_w & ~hs_prev_q;
  wire hs_fall_w  = ~hs_w & hs_prev_q;
  wire idx_rise_w = pin_sync_q[PIN_IDX] & ~idx_prev_q;

  // Sequencer state
  home_state_e         st_q;
  home_state_e         st_d;
  logic                dir_q;
  logic                dir_d;
  logic [METHOD_W-1:0] method_q;
  logic [METHOD_W-1:0] method_d;
  logic                done_q;
  logic                done_d;
  logic                error_q;
  logic                error_d;
  logic                fast_q;
  logic                moving_q;
  logic [SPEED_W-1:0]  speed_q;

  // Direction of the slow leg that starts inside the switch
  function automatic logic inside_dir(input logic [METHOD_W-1:0] m);
    inside_dir = (m == MTH_07 || m == MTH_08) ? DIR_REV : DIR_FWD;
  endfunction : inside_dir

  // Direction of the initial fast search
  function automatic logic fast_dir(input logic [METHOD_W-1:0] m);
    fast_dir = (m == MTH_11) ? DIR_REV : DIR_FWD;
  endfunction : fast_dir

  wire start_ok_w = (method_i >= MTH_06) && (method_i <= MTH_11);
  wire m6_w       = (method_q == MTH_06);
  wire two_leg_w  = (method_q == MTH_08) || (method_q == MTH_09);
  // Only the limit in the direction of travel counts; method 6 ignores limits
  wire lim_hit_w  = !m6_w && ((dir_q == DIR_FWD) ? flim_w : rlim_w);

  always_comb begin
    st_d     = st_q;
    dir_d    = dir_q;
    method_d = method_q;
    done_d   = done_q;
    error_d  = error_q;
    if (start_i) begin
      done_d  = 1'b0;
      error_d = !start_ok_w;
      if (!start_ok_w) begin
        st_d = S_IDLE;
      end else begin
        method_d = method_i;
        if (method_i == MTH_06) begin
          if (hs_w) begin
            st_d  = S_FAST;
            dir_d = DIR_FWD;
          end else begin
            st_d  = S_SLOW2;
            dir_d = DIR_REV;
          end
        end else if (hs_w) begin
          st_d  = S_SLOW1;
          dir_d = inside_dir(method_i);
        end else begin
          st_d  = S_FAST;
          dir_d = fast_dir(method_i);
        end
      end
    end else if (stop_i) begin
      st_d = S_IDLE;
    end else begin
      case (st_q)
        S_FAST: begin
          if (m6_w) begin
            if (hs_fall_w) begin
              st_d  = S_SLOW2;
              dir_d = DIR_REV;
            end
          end else if (hs_rise_w) begin
            st_d  = S_SLOW1;
            dir_d = inside_dir(method_q);
          end else if (lim_hit_w) begin
            st_d  = S_BACK;
            dir_d = ~dir_q;
          end
        end
        S_BACK: begin
          if (hs_rise_w) begin
            st_d  = S_SLOW1;
            dir_d = inside_dir(method_q);
          end
        end
        S_SLOW1: begin
          if (hs_fall_w) begin
            if (two_leg_w) begin
              st_d  = S_SLOW2;
              dir_d = ~dir_q;
            end else begin
              st_d = S_ARM;
            end
          end
        end
        S_SLOW2: begin
          if (hs_rise_w) begin
            st_d = S_ARM;
          end
        end
        S_ARM: begin
          // Index already high when armed is not taken; a fresh rise is needed
          if (idx_rise_w) begin
            st_d   = S_DONE;
            done_d = 1'b1;
          end
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end
  end

  wire fast_d_w   = (st_d == S_FAST) || (st_d == S_BACK);
  wire moving_d_w = (st_d != S_IDLE) && (st_d != S_DONE);
  wire [SPEED_W-1:0] speed_d_w = !moving_d_w ? SPEED_ZERO :
                                 fast_d_w ? fast_speed_i : slow_speed_i;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q     <= S_IDLE;
      dir_q    <= DIR_FWD;
      method_q <= METHOD_RST;
      done_q   <= 1'b0;
      error_q  <= 1'b0;
      fast_q   <= 1'b0;
      moving_q <= 1'b0;
      speed_q  <= SPEED_ZERO;
    end else begin
      st_q     <= st_d;
      dir_q    <= dir_d;
      method_q <= method_d;
      done_q   <= done_d;
      error_q  <= error_d;
      fast_q   <= fast_d_w;
      moving_q <= moving_d_w;
      speed_q  <= speed_d_w;
    end
  end

  assign dir_fwd_o = dir_q;
  assign fast_o    = fast_q;
  assign moving_o  = moving_q;
  assign speed_o   = speed_q;
  assign done_o    = done_q;
  assign error_o   = error_q;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_go(logic [METHOD_W-1:0] m, logic h);
    start_i && method_i == m && hs_w == h;
  endsequence

  sequence s_quiet;
    !start_i && !stop_i;
  endsequence

  sequence s_slow(home_state_e s, logic d);
    st_q == s && dir_q == d && !fast_q && moving_q;
  endsequence

  sequence s_fast(home_state_e s, logic d);
    st_q == s && dir_q == d && fast_q && moving_q;
  endsequence

  property p_m6_low;
    s_go(MTH_06, 1'b0) |=> s_slow(S_SLOW2, DIR_REV);
  endproperty
  a_m6_low: assert property (p_m6_low) else $error("m6 low start wrong");

  property p_m6_go;
    s_go(MTH_06, 1'b1)
      |=> s_fast(S_FAST, DIR_FWD);
  endproperty
  a_m6_go: assert property (p_m6_go) else $error("m6 high start wrong");

  property p_m6_high;
    (st_q == S_FAST && method_q == MTH_06 && hs_fall_w) and s_quiet
      |=> s_slow(S_SLOW2, DIR_REV);
  endproperty
  a_m6_high: assert property (p_m6_high) else $error("m6 fall step wrong");

  property p_m7_go;
    s_go(MTH_07, 1'b0)
      |=> s_fast(S_FAST, DIR_FWD);
  endproperty
  a_m7_go: assert property (p_m7_go) else $error("m7 low start wrong");

  property p_m7_rise;
    st_q == S_FAST && method_q == MTH_07 && hs_rise_w && !start_i && !stop_i
      |=> s_slow(S_SLOW1, DIR_REV);
  endproperty
  a_m7_rise: assert property (p_m7_rise) else $error("m7 rise step wrong");

  property p_m7_limit;
    st_q == S_FAST && method_q == MTH_07 && flim_w && !hs_rise_w && !start_i && !stop_i
      |=> s_fast(S_BACK, DIR_REV);
  endproperty
  a_m7_limit: assert property (p_m7_limit) else $error("m7 limit reversal wrong");

  property p_m7_high;
    s_go(MTH_07, 1'b1) |=> s_slow(S_SLOW1, DIR_REV);
  endproperty
  a_m7_high: assert property (p_m7_high) else $error("m7 high start wrong");

  property p_m8_fall;
    st_q == S_SLOW1 && method_q == MTH_08 && hs_fall_w && !start_i && !stop_i
      |=> s_slow(S_SLOW2, DIR_FWD);
  endproperty
  a_m8_fall: assert property (p_m8_fall) else $error("m8 turn on fall wrong");

  property p_m8_rise;
    st_q == S_FAST && method_q == MTH_08 && hs_rise_w && !start_i && !stop_i
      |=> s_slow(S_SLOW1, DIR_REV);
  endproperty
  a_m8_rise: assert property (p_m8_rise) else $error("m8 rise step wrong");

  property p_m8_back;
    st_q == S_BACK && method_q == MTH_08 && hs_rise_w && !start_i && !stop_i
      |=> s_slow(S_SLOW1, DIR_REV);
  endproperty
  a_m8_back: assert property (p_m8_back) else $error("m8 back rise wrong");

  property p_m8_high;
    s_go(MTH_08, 1'b1) |=> s_slow(S_SLOW1, DIR_REV);
  endproperty
  a_m8_high: assert property (p_m8_high) else $error("m8 high start wrong");

  property p_m9_fall;
    st_q == S_SLOW1 && method_q == MTH_09 && hs_fall_w && !start_i && !stop_i
      |=> s_slow(S_SLOW2, DIR_REV);
  endproperty
  a_m9_fall: assert property (p_m9_fall) else $error("m9 turn on fall wrong");

  property p_m9_back;
    st_q == S_BACK && method_q == MTH_09 && hs_rise_w && !start_i && !stop_i
      |=> s_slow(S_SLOW1, DIR_FWD);
  endproperty
  a_m9_back: assert property (p_m9_back) else $error("m9 back rise wrong");

  property p_m9_high;
    s_go(MTH_09, 1'b1) |=> s_slow(S_SLOW1, DIR_FWD);
  endproperty
  a_m9_high: assert property (p_m9_high) else $error("m9 high start wrong");

  property p_m10_fall;
    st_q == S_SLOW1 && method_q == MTH_10 && hs_fall_w && !start_i && !stop_i
      |=> s_slow(S_ARM, DIR_FWD);
  endproperty
  a_m10_fall: assert property (p_m10_fall) else $error("m10 arm on fall wrong");

  property p_m10_back;
    st_q == S_BACK && method_q == MTH_10 && hs_rise_w && !start_i && !stop_i
      |=> s_slow(S_SLOW1, DIR_FWD);
  endproperty
  a_m10_back: assert property (p_m10_back) else $error("m10 back rise wrong");

  property p_m10_high;
    s_go(MTH_10, 1'b1) |=> s_slow(S_SLOW1, DIR_FWD);
  endproperty
  a_m10_high: assert property (p_m10_high) else $error("m10 high start wrong");

  property p_m11_low;
    s_go(MTH_11, 1'b0) |=> s_fast(S_FAST, DIR_REV);
  endproperty
  a_m11_low: assert property (p_m11_low) else $error("m11 low start wrong");

  property p_m11_limit;
    st_q == S_FAST && method_q == MTH_11 && rlim_w && !hs_rise_w && !start_i && !stop_i
      |=> s_fast(S_BACK, DIR_FWD);
  endproperty
  a_m11_limit: assert property (p_m11_limit) else $error("m11 limit reversal wrong");

  property p_m11_high;
    s_go(MTH_11, 1'b1) |=> s_slow(S_SLOW1, DIR_FWD);
  endproperty
  a_m11_high: assert property (p_m11_high) else $error("m11 high start wrong");

  property p_speed_sel;
    ##1 moving_o |-> speed_o == (fast_o ? $past(fast_speed_i) : $past(slow_speed_i));
  endproperty
  a_speed_sel: assert property (p_speed_sel) else $error("speed source wrong");

  property p_sync;
    ##2 1'b1 |-> hs_w == $past(home_switch_i, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("home switch sync depth wrong");

  property p_done;
    st_q == S_ARM && idx_rise_w && !start_i && !stop_i
      |=> done_o && !moving_o && speed_o == SPEED_ZERO ##1 (done_o || $past(start_i));
  endproperty
  a_done: assert property (p_done) else $error("done or zero speed wrong");

endmodule : homing_seq

/* File: tb/motion_model.sv */
// Axis model: position driven by commanded motion, giving home, limit and index pins
`timescale 1ns/1ps
module motion_model
  import homing_pkg::*;
#(
  parameter int HOME_LO = 400,  // Home cam lower edge
  parameter int HOME_HI = 600,  // Home cam upper edge
  parameter int FWD_END = 1000, // Forward limit position
  parameter int REV_END = 0     // Reverse limit position
)(
  input  wire logic               clock_i,       // Bench clock
  input  wire logic               load_i,        // Place the axis
  input  wire logic signed [31:0] load_pos_i,    // Position to place
  input  wire logic               dir_fwd_i,     // Commanded direction
  input  wire logic               moving_i,      // Commanded motion
  input  wire logic [SPEED_W-1:0] speed_i,       // Commanded step per cycle
  output logic                    home_switch_o, // Home switch pin
  output logic                    fwd_limit_o,   // Forward limit pin
  output logic                    rev_limit_o,   // Reverse limit pin
  output logic                    index_o,       // Encoder index pin
  output int                      pos_o          // Current position
);
  int pos_q = 500;

  // Axis integrates the commanded speed, so a wrong speed shows as wrong travel
  always @(posedge clock_i) begin
    if (load_i) begin
      pos_q <= load_pos_i;
    end else if (moving_i === 1'b1) begin
      pos_q <= (dir_fwd_i === DIR_FWD) ? pos_q + int'(speed_i) : pos_q - int'(speed_i);
    end
  end

  assign pos_o         = pos_q;
  assign home_switch_o = (pos_q >= HOME_LO) && (pos_q <= HOME_HI);
  assign fwd_limit_o   = (pos_q >= FWD_END);
  assign rev_limit_o   = (pos_q <= REV_END);
  // Index window four counts wide: seen at slow speed, may be skipped at fast
  assign index_o       = (pos_q[4:0] >= 5'h10) && (pos_q[4:0] <= 5'h13);
endmodule : motion_model

/* File: tb/tb_homing_seq.sv */
// Self-checking bench for the homing sequencer, methods 6 to 11
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module tb_homing_seq;
  import homing_pkg::*;
  logic                clock_i       = 1'b0;
  logic                rstn_i        = 1'b0;
  logic                start_i       = 1'b0;
  logic                stop_i        = 1'b0;
  logic [METHOD_W-1:0] method_i      = METHOD_RST;
  logic [SPEED_W-1:0]  fast_speed_i  = 16'h0004;
  logic [SPEED_W-1:0]  slow_speed_i  = 16'h0001;
  logic                load          = 1'b0;
  int                  load_pos      = 500;
  logic                home_switch, fwd_limit, rev_limit, index_p;
  logic                dir_fwd_o, fast_o, moving_o, done_o, error_o;
  logic [SPEED_W-1:0]  speed_o;
  int                  pos;
  int                  errors        = 0;
  int                  n_tests       = 0;

  homing_seq dut (.clock_i(clock_i), .rstn_i(rstn_i), .start_i(start_i), .stop_i(stop_i),
    .method_i(method_i), .fast_speed_i(fast_speed_i), .slow_speed_i(slow_speed_i),
    .home_switch_i(home_switch), .fwd_limit_i(fwd_limit), .rev_limit_i(rev_limit),
    .index_i(index_p), .dir_fwd_o(dir_fwd_o), .fast_o(fast_o), .moving_o(moving_o),
    .speed_o(speed_o), .done_o(done_o), .error_o(error_o));

  motion_model axis (.clock_i(clock_i), .load_i(load), .load_pos_i(load_pos),
    .dir_fwd_i(dir_fwd_o), .moving_i(moving_o), .speed_i(speed_o),
    .home_switch_o(home_switch), .fwd_limit_o(fwd_limit), .rev_limit_o(rev_limit),
    .index_o(index_p), .pos_o(pos));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Place axis, let synchronisers settle, then pulse start
  task automatic launch(input int m, input int p);
    @(posedge clock_i);
    load     <= 1'b1;
    load_pos <= p;
    @(posedge clock_i);
    load     <= 1'b0;
    repeat (4) @(posedge clock_i);
    method_i <= m[METHOD_W-1:0];
    start_i  <= 1'b1;
    @(posedge clock_i);
    start_i  <= 1'b0;
  endtask : launch

  // Segment codes: 0 rev slow, 1 rev fast, 2 fwd slow, 3 fwd fast
  task automatic run_case(input int m, input int p, input string exp);
    string      got;
    logic [1:0] seg;
    logic [1:0] last;
    int         k;
    got = "";
    last = 2'b00;
    @(posedge clock_i);
    fast_speed_i <= 16'h0002 + SPEED_W'($urandom % 5);
    launch(m, p + int'($urandom % 40) - 20);
    // Let the start edge settle, else the old done ends the wait at once
    #1;
    for (k = 0; k < 30000 && done_o !== 1'b1; k++) begin
      @(posedge clock_i);
      #1;
      if (moving_o === 1'b1) begin
        `CHK("speed", fast_o ? fast_speed_i : slow_speed_i, speed_o)
        seg = {dir_fwd_o, fast_o};
        if (got.len() == 0 || seg !== last) begin
          got = {got, $sformatf("%0d", seg)};
        end
        last = seg;
      end
    end
    if (k >= 30000) begin
      errors++;
      $display("FAIL timeout method %0d", m);
      wrap_up();
    end
    `CHK("segments", 1'b1, got == exp)
    `CHK("moving at done", 1'b0, moving_o)
    `CHK("speed at done", SPEED_ZERO, speed_o)
    `CHK("stop near index", 1'b1, pos[4:0] >= 5'h0C && pos[4:0] <= 5'h18)
    repeat (12) @(posedge clock_i);
    #1;
    `CHK("done held", 1'b1, done_o)
  endtask : run_case

  initial begin
    void'($urandom(78261));
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    #1;
    `CHK("reset dir", DIR_FWD, dir_fwd_o)
    `CHK("reset done", 1'b0, done_o)
    run_case(6, 800, "0");
    run_case(6, 500, "30");
    run_case(7, 200, "30");
    run_case(7, 800, "310");
    run_case(7, 500, "0");
    run_case(8, 200, "302");
    run_case(8, 800, "3102");
    run_case(8, 500, "02");
    run_case(9, 200, "320");
    run_case(9, 800, "3120");
    run_case(9, 500, "20");
    run_case(10, 200, "32");
    run_case(10, 800, "312");
    run_case(10, 500, "2");
    run_case(11, 800, "12");
    run_case(11, 200, "132");
    run_case(11, 500, "2");
    // Abort mid-search: motion ends, a fresh start cleared done
    launch(10, 200);
    repeat (20) @(posedge clock_i);
    #1;
    `CHK("done cleared by start", 1'b0, done_o)
    @(posedge clock_i);
    stop_i <= 1'b1;
    @(posedge clock_i);
    stop_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("moving after stop", 1'b0, moving_o)
    // Codes just outside the supported range are refused
    launch(5, 500);
    #1;
    `CHK("error low code", 1'b1, error_o)
    `CHK("refused no motion", 1'b0, moving_o)
    launch(12, 500);
    #1;
    `CHK("error high code", 1'b1, error_o)
    run_case(11, 500, "2");
    `CHK("error cleared", 1'b0, error_o)
    wrap_up();
  end
endmodule : tb_homing_seq
